// ==== verilog/gfm_pkg.sv ====
// Purpose: constants and types for the forced-function gpio block
// Assumes: apb slave, 32-bit data, 100 MHz clk
// Notes:   register offsets are byte addresses
//
// Overview of operation
// - forced pin functions apply from every reset
// - port a bit 7 open-drain regulator enable
// - port c bits 0,3 pulled up, 2 driven
// - port c bit 4 mode-select or serial data
// - jtag after reset, only tool switches mode
// - disable bit returns debug pins to gpio
// - disable write ignored while debug active
// - tool activity in reset reclaims, sets flag
// - debug active equals power-up request high
// - full reset from por, pin, watchdog, sysreset
// - full reset makes all unforced pins floating input
// - full reset sets regulator enable bit
// - full reset clears debug disable bit
// - boot select only after pin or por reset
// - port a bit 5 pulled up, then sampled
// - boot pin floats after sample, level readable
// - analog: drivers, pulls off, input reads one
// - floating input: no pulls, no drive
// - pull input: out bit selects pull direction
// - open-drain: zero drives low, one floats
// - push-pull drives out bit, input tracks pin
// - set and clear registers update atomically
// - output data reads last written value
// - four-bit config decode of seven modes
// - alternate output without peripheral drives zero
package gfm_pkg;
   localparam int NPORT = 3;
   localparam int NPIN  = 24;
   // register byte offsets, per port stride
   localparam logic [11:0] OFS_CFGL   = 12'h000;
   localparam logic [11:0] OFS_CFGH   = 12'h004;
   localparam logic [11:0] OFS_IN     = 12'h008;
   localparam logic [11:0] OFS_OUT    = 12'h00C;
   localparam logic [11:0] OFS_SET    = 12'h010;
   localparam logic [11:0] OFS_CLR    = 12'h014;
   localparam logic [11:0] PORT_STEP  = 12'h040;
   localparam logic [11:0] OFS_DBGCFG = 12'h100;
   localparam logic [11:0] OFS_DBGST  = 12'h104;
   // debug config bits
   localparam int BIT_EXTREG = 4;
   localparam int BIT_DBGDIS = 5;
   // debug status bits
   localparam int BIT_FORCED = 1;
   localparam int BIT_SWEN   = 2;
   localparam int BIT_BOOT   = 3;
   // mode codes
   localparam logic [3:0] CFG_ANALOG = 4'h0;
   localparam logic [3:0] CFG_FLOAT  = 4'h4;
   localparam logic [3:0] CFG_PULL   = 4'h8;
   localparam logic [3:0] CFG_PP     = 4'h1;
   localparam logic [3:0] CFG_OD     = 4'h5;
   localparam logic [3:0] CFG_ALTPP  = 4'h9;
   localparam logic [3:0] CFG_ALTOD  = 4'hD;
   // pin indices
   localparam int PIN_REGEN = 7;
   localparam int PIN_BOOT  = 5;
   localparam int PIN_TRST  = 16;
   localparam int PIN_TDO   = 18;
   localparam int PIN_TDI   = 19;
   localparam int PIN_TMS   = 20;
   // boot sample delay
   localparam int BOOT_CLKS = 512;
   typedef struct packed {
      logic drv_lo;
      logic drv_hi;
      logic pull_up;
      logic pull_dn;
   } gfm_pad_t;
   typedef struct packed {
      logic tck_sel_sw;
      logic tdo;
      logic swdio_out;
      logic swdio_oe;
   } gfm_dbg_t;
endpackage

// ==== verilog/gfm_boot.sv ====
// Purpose: boot select capture after pin or por reset
// Assumes: delay counted on clk
// Notes:   none
`timescale 1ns/1ps
module gfm_boot
   import gfm_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // reset cause and pin
   input  wire logic boot_reset_src,
   input  wire logic boot_pin,
   // result
   output logic      boot_pullup,
   output logic      boot_sel_n_ff
);
   logic [9:0] cnt_ff;
   logic       busy_ff;
   logic       arm_ff;
   wire        last = (cnt_ff == 10'(BOOT_CLKS - 1));
   assign boot_pullup = busy_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff        <= '0;
         busy_ff       <= 1'b1;
         arm_ff        <= 1'b0;
         boot_sel_n_ff <= 1'b1;
      end else begin
         if (cnt_ff == '0 && busy_ff) arm_ff <= boot_reset_src;
         if (busy_ff) cnt_ff <= cnt_ff + 10'd1;
         if (busy_ff && last) begin
            busy_ff <= 1'b0;
            if (arm_ff) boot_sel_n_ff <= boot_pin;
         end
      end
   end
endmodule // gfm_boot

// ==== verilog/gfm_pad.sv ====
// Purpose: one pin mode decode
// Assumes: pad struct drives physical pad
// Notes:   analog ties input high
`timescale 1ns/1ps
module gfm_pad
   import gfm_pkg::*;
(
   // configuration
   input  wire logic [3:0] cfg,
   input  wire logic       out_bit,
   input  wire logic       alt_bit,
   input  wire logic       pin_in,
   // pad side
   output gfm_pad_t        pad,
   output logic            din
);
   wire is_od  = (cfg == CFG_OD) || (cfg == CFG_ALTOD);
   wire is_pp  = (cfg == CFG_PP) || (cfg == CFG_ALTPP);
   wire is_alt = (cfg == CFG_ALTPP) || (cfg == CFG_ALTOD);
   wire val    = is_alt ? alt_bit : out_bit;
   assign pad.drv_lo  = (is_od || is_pp) && !val;
   assign pad.drv_hi  = is_pp && val;
   assign pad.pull_up = (cfg == CFG_PULL) && out_bit;
   assign pad.pull_dn = (cfg == CFG_PULL) && !out_bit;
   assign din         = (cfg == CFG_ANALOG) ? 1'b1 : pin_in;
endmodule // gfm_pad

// ==== verilog/gfm_top.sv ====
// Purpose: gpio ports with forced debug, regulator and boot pins
// Assumes: apb slave, single clock, rst_n is full chip reset
// Notes:   alternate peripheral data absent, tied to zero
`timescale 1ns/1ps
module gfm_top
   import gfm_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // reset causes
   input  wire logic              boot_reset_src,
   input  wire logic              reset_held,
   // apb
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // debug port
   input  wire logic              debug_powerup_request,
   input  wire logic              dbg_sw_mode,
   input  wire logic              dbg_tdo,
   input  wire logic              dbg_swdio_out,
   input  wire logic              dbg_swdio_oe,
   output logic                   dbg_trst,
   output logic                   dbg_tdi,
   output logic                   dbg_tms,
   // regulator enable
   input  wire logic              reg_en,
   // pins
   input  wire logic [NPIN-1:0]   pin_in,
   output logic [NPIN-1:0]        pin_drv_lo,
   output logic [NPIN-1:0]        pin_drv_hi,
   output logic [NPIN-1:0]        pin_pull_up,
   output logic [NPIN-1:0]        pin_pull_dn,
   output logic                   boot_select_n
);
   // ---------------------------------------
   // registers
   // ---------------------------------------
   logic [3:0]        cfg_ff [NPIN];
   logic [NPIN-1:0]   out_ff;
   logic              extreg_ff;
   logic              dbgdis_ff;
   logic              forced_ff;
   logic              pend_ff;
   logic [31:0]       prdata_ff;
   logic [NPIN-1:0]   din;
   gfm_pad_t          pad [NPIN];
   logic              boot_pu;

   // ---------------------------------------
   // apb decode
   // ---------------------------------------
   wire        acc    = psel && penable;
   wire        wr     = acc && pwrite;
   wire [1:0]  pidx   = paddr[7:6];
   wire [11:0] lofs   = {6'd0, paddr[5:0]};
   wire        in_prt = (paddr[11:8] == 4'h0) && (pidx < 2'(NPORT));
   wire        hit_dc = (paddr == OFS_DBGCFG);
   wire        hit_ds = (paddr == OFS_DBGST);
   wire        hit_pr = in_prt && (lofs <= OFS_CLR) && (lofs[1:0] == 2'b00);
   wire        mapped = hit_dc || hit_ds || hit_pr;
   wire        dbg_act = debug_powerup_request;
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;
   assign prdata  = prdata_ff;

   // ---------------------------------------
   // config and output data
   // ---------------------------------------
   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : g_pin
         localparam int P = g / 8;
         localparam int B = g % 8;
         wire hp = wr && in_prt && (pidx == 2'(P));
         wire hi_half = (B >= 4);
         wire wcfg = hp && (lofs == (hi_half ? OFS_CFGH : OFS_CFGL));
         wire wout = hp && (lofs == OFS_OUT);
         wire wset = hp && (lofs == OFS_SET) && pwdata[B];
         wire wclr = hp && (lofs == OFS_CLR) && pwdata[B];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               cfg_ff[g] <= CFG_FLOAT;
               out_ff[g] <= 1'b0;
            end else begin
               if (wcfg) cfg_ff[g] <= pwdata[(B%4)*4 +: 4];
               if (wout) out_ff[g] <= pwdata[B];
               else if (wset) out_ff[g] <= 1'b1;
               else if (wclr) out_ff[g] <= 1'b0;
            end
         end
         gfm_pad u_pad (
            .cfg     (cfg_ff[g]),
            .out_bit (out_ff[g]),
            .alt_bit (1'b0),
            .pin_in  (pin_in[g]),
            .pad     (pad[g]),
            .din     (din[g])
         );
      end
   endgenerate

   // ---------------------------------------
   // debug config and status
   // ---------------------------------------
   wire wr_dc = wr && hit_dc;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         extreg_ff <= 1'b1;
         dbgdis_ff <= 1'b0;
         forced_ff <= 1'b0;
         pend_ff   <= 1'b0;
      end else begin
         pend_ff <= reset_held && dbg_act;
         if (wr_dc) extreg_ff <= pwdata[BIT_EXTREG];
         if (pend_ff && dbgdis_ff) begin
            dbgdis_ff <= 1'b0;
            forced_ff <= 1'b1;
         end else if (wr_dc && !(pwdata[BIT_DBGDIS] && dbg_act)) begin
            dbgdis_ff <= pwdata[BIT_DBGDIS];
         end
      end
   end

   // ---------------------------------------
   // read mux
   // ---------------------------------------
   logic [7:0] rd_in;
   logic [7:0] rd_out;
   logic [31:0] rd_cfg;
   always_comb begin
      rd_in  = din[pidx*8 +: 8];
      rd_out = out_ff[pidx*8 +: 8];
      rd_cfg = '0;
      for (int i = 0; i < 4; i++) begin
         rd_cfg[i*4 +: 4] = cfg_ff[pidx*8 + (lofs == OFS_CFGH ? 4 : 0) + i];
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= '0;
         if (paddr == OFS_DBGCFG) begin
            prdata_ff[BIT_EXTREG] <= extreg_ff;
            prdata_ff[BIT_DBGDIS] <= dbgdis_ff;
         end else if (paddr == OFS_DBGST) begin
            prdata_ff[BIT_FORCED] <= forced_ff;
            prdata_ff[BIT_SWEN]   <= dbg_sw_mode;
            prdata_ff[BIT_BOOT]   <= boot_select_n;
         end else if (in_prt && (lofs == OFS_CFGL || lofs == OFS_CFGH)) begin
            prdata_ff <= rd_cfg;
         end else if (in_prt && lofs == OFS_IN) begin
            prdata_ff <= {24'd0, rd_in};
         end else if (in_prt && lofs == OFS_OUT) begin
            prdata_ff <= {24'd0, rd_out};
         end
      end
   end

   // ---------------------------------------
   // boot select
   // ---------------------------------------
   gfm_boot u_boot (
      .clk            (clk),
      .rst_n          (rst_n),
      .boot_reset_src (boot_reset_src),
      .boot_pin       (pin_in[PIN_BOOT]),
      .boot_pullup    (boot_pu),
      .boot_sel_n_ff  (boot_select_n)
   );

   // ---------------------------------------
   // forced pin overrides
   // ---------------------------------------
   wire dbg_on = !dbgdis_ff;
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         pin_drv_lo[i]  = pad[i].drv_lo;
         pin_drv_hi[i]  = pad[i].drv_hi;
         pin_pull_up[i] = pad[i].pull_up;
         pin_pull_dn[i] = pad[i].pull_dn;
      end
      if (extreg_ff) begin
         pin_drv_lo[PIN_REGEN]  = !reg_en;
         pin_drv_hi[PIN_REGEN]  = 1'b0;
         pin_pull_up[PIN_REGEN] = 1'b0;
         pin_pull_dn[PIN_REGEN] = 1'b0;
      end
      if (boot_pu) begin
         pin_drv_lo[PIN_BOOT]  = 1'b0;
         pin_drv_hi[PIN_BOOT]  = 1'b0;
         pin_pull_up[PIN_BOOT] = 1'b1;
         pin_pull_dn[PIN_BOOT] = 1'b0;
      end
      if (dbg_on) begin
         pin_drv_lo[PIN_TRST]  = 1'b0;
         pin_drv_hi[PIN_TRST]  = 1'b0;
         pin_pull_up[PIN_TRST] = 1'b1;
         pin_pull_dn[PIN_TRST] = 1'b0;
         pin_drv_lo[PIN_TDI]   = 1'b0;
         pin_drv_hi[PIN_TDI]   = 1'b0;
         pin_pull_up[PIN_TDI]  = 1'b1;
         pin_pull_dn[PIN_TDI]  = 1'b0;
         pin_drv_lo[PIN_TDO]   = !dbg_tdo;
         pin_drv_hi[PIN_TDO]   = dbg_tdo;
         pin_pull_up[PIN_TDO]  = 1'b0;
         pin_pull_dn[PIN_TDO]  = 1'b0;
         pin_pull_dn[PIN_TMS]  = 1'b0;
         if (dbg_sw_mode) begin
            pin_drv_lo[PIN_TMS]  = dbg_swdio_oe && !dbg_swdio_out;
            pin_drv_hi[PIN_TMS]  = dbg_swdio_oe && dbg_swdio_out;
            pin_pull_up[PIN_TMS] = 1'b0;
         end else begin
            pin_drv_lo[PIN_TMS]  = 1'b0;
            pin_drv_hi[PIN_TMS]  = 1'b0;
            pin_pull_up[PIN_TMS] = 1'b1;
         end
      end
   end
   assign dbg_trst = dbg_on ? pin_in[PIN_TRST] : 1'b1;
   assign dbg_tdi  = dbg_on ? pin_in[PIN_TDI] : 1'b1;
   assign dbg_tms  = dbg_on ? pin_in[PIN_TMS] : 1'b1;
endmodule // gfm_top

// ==== tb/gfm_pins.sv ====
// Purpose: pin level model for all 24 pads
// Assumes: strong drive beats external drive beats pulls
// Notes:   a floating pin toggles every cycle
`timescale 1ns/1ps
module gfm_pins
   import gfm_pkg::*;
(
   // clock
   input  wire logic            clk,
   // pad controls and external drive
   input  wire logic [NPIN-1:0] pin_drv_lo,
   input  wire logic [NPIN-1:0] pin_drv_hi,
   input  wire logic [NPIN-1:0] pin_pull_up,
   input  wire logic [NPIN-1:0] pin_pull_dn,
   input  wire logic [NPIN-1:0] ext_en,
   input  wire logic [NPIN-1:0] ext_val,
   // resolved level
   output logic [NPIN-1:0]      pin_in
);
   logic tog_ff = 1'b0;
   always_ff @(posedge clk) tog_ff <= ~tog_ff;
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         if (pin_drv_lo[i]) pin_in[i] = 1'b0;
         else if (pin_drv_hi[i]) pin_in[i] = 1'b1;
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pin_pull_up[i] | pin_pull_dn[i]) pin_in[i] = pin_pull_up[i];
         else pin_in[i] = tog_ff ^ i[0];
      end
   end
endmodule // gfm_pins

// ==== tb/gfm_chk.sv ====
// Purpose: port assertions for gfm_top
// Assumes: one clock, async low reset
// Notes:   mirrors debug config bits from apb writes
`timescale 1ns/1ps
module gfm_chk
   import gfm_pkg::*;
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst_n,
   // watched ports
   input  wire logic            reset_held,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   input  wire logic            debug_powerup_request,
   input  wire logic            dbg_sw_mode,
   input  wire logic            dbg_tdo,
   input  wire logic            dbg_swdio_out,
   input  wire logic            dbg_swdio_oe,
   input  wire logic            dbg_trst,
   input  wire logic            dbg_tdi,
   input  wire logic            dbg_tms,
   input  wire logic            reg_en,
   input  wire logic [NPIN-1:0] pin_in,
   input  wire logic [NPIN-1:0] pin_drv_lo,
   input  wire logic [NPIN-1:0] pin_drv_hi,
   input  wire logic [NPIN-1:0] pin_pull_up,
   input  wire logic            boot_select_n
);
   // ----
   // mirror of config bits and boot counter
   // ----
   wire       wr_cfg = psel & penable & pwrite & (paddr == OFS_DBGCFG);
   logic       ext_ff, dis_ff, pend_ff;
   logic [9:0] cnt_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_ff <= 1'b1;
         dis_ff <= 1'b0;
         pend_ff <= 1'b0;
         cnt_ff <= 10'h000;
      end else begin
         if (wr_cfg) ext_ff <= pwdata[BIT_EXTREG];
         pend_ff <= reset_held & debug_powerup_request;
         if (pend_ff & dis_ff) dis_ff <= 1'b0;
         else if (wr_cfg) dis_ff <= pwdata[BIT_DBGDIS] & (dis_ff | ~debug_powerup_request);
         if (cnt_ff != 10'h3FF) cnt_ff <= cnt_ff + 10'h001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   regen_drive_a: assert property (ext_ff |->
      pin_drv_lo[PIN_REGEN] == !reg_en && !pin_drv_hi[PIN_REGEN]) else $error("regen pin");
   tdo_push_a: assert property (!dis_ff && !dbg_sw_mode |->
      pin_drv_hi[PIN_TDO] == dbg_tdo && pin_drv_lo[PIN_TDO] == !dbg_tdo) else $error("tdo pin");
   trst_tdi_a: assert property (!dis_ff |-> pin_pull_up[PIN_TRST] &&
      pin_pull_up[PIN_TDI] && dbg_trst == pin_in[PIN_TRST] && dbg_tdi == pin_in[PIN_TDI])
      else $error("trst tdi pins");
   tms_jtag_a: assert property (!dis_ff && !dbg_sw_mode |-> pin_pull_up[PIN_TMS] &&
      !pin_drv_lo[PIN_TMS] && dbg_tms == pin_in[PIN_TMS]) else $error("tms pin");
   swdio_dir_a: assert property (!dis_ff && dbg_sw_mode |->
      pin_drv_hi[PIN_TMS] == (dbg_swdio_oe & dbg_swdio_out) && !pin_pull_up[PIN_TMS] &&
      pin_drv_lo[PIN_TMS] == (dbg_swdio_oe & !dbg_swdio_out)) else $error("swdio pin");
   dis_gpio_a: assert property (dis_ff |-> dbg_trst && dbg_tdi && dbg_tms)
      else $error("debug inputs not idle");
   reclaim_pins_a: assert property (reset_held && debug_powerup_request |->
      ##[1:2] pin_pull_up[PIN_TRST]) else $error("no reclaim");
   boot_pull_a: assert property (cnt_ff < 10'h1FE |-> pin_pull_up[PIN_BOOT])
      else $error("boot pull-up");
   boot_hold_a: assert property (cnt_ff > 10'h202 |-> $stable(boot_select_n))
      else $error("boot level moved");
   cover property (reset_held && debug_powerup_request);
   cover property (!dis_ff && dbg_sw_mode && dbg_swdio_oe);
   cover property ($fell(boot_select_n));
endmodule // gfm_chk
bind gfm_top gfm_chk u_chk (
   .clk (clk), .rst_n (rst_n), .reset_held (reset_held), .psel (psel), .penable (penable),
   .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata),
   .debug_powerup_request (debug_powerup_request), .dbg_sw_mode (dbg_sw_mode),
   .dbg_tdo (dbg_tdo), .dbg_swdio_out (dbg_swdio_out), .dbg_swdio_oe (dbg_swdio_oe),
   .dbg_trst (dbg_trst), .dbg_tdi (dbg_tdi), .dbg_tms (dbg_tms), .reg_en (reg_en),
   .pin_in (pin_in), .pin_drv_lo (pin_drv_lo), .pin_drv_hi (pin_drv_hi),
   .pin_pull_up (pin_pull_up), .boot_select_n (boot_select_n)
);

// ==== tb/gfm_top_bench.sv ====
// Purpose: self-checking bench for gfm_top
// Assumes: pready answers in the access cycle
// Notes:   pads observed at the falling edge
`timescale 1ns/1ps
module gfm_top_bench
   import gfm_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, boot_reset_src = 1'b0, reset_held = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reg_en = 1'b1;
   logic debug_powerup_request = 1'b0, dbg_sw_mode = 1'b0, dbg_tdo = 1'b0;
   logic dbg_swdio_out = 1'b0, dbg_swdio_oe = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic pready, pslverr, errv, dbg_trst, dbg_tdi, dbg_tms, boot_select_n;
   logic [NPIN-1:0] ext_en = '0, ext_val = '0, pin_in;
   logic [NPIN-1:0] pin_drv_lo, pin_drv_hi, pin_pull_up, pin_pull_dn;
   logic [15:0] mt [10] = '{16'h0103, 16'h4100, 16'h8012, 16'h8123, 16'h1082,
                            16'h1143, 16'h5082, 16'h5100, 16'h9182, 16'hD182};
   int err_count = 0, comparisons = 0;
   gfm_top dut (
      .clk (clk), .rst_n (rst_n), .boot_reset_src (boot_reset_src), .reset_held (reset_held),
      .psel (psel), .penable (penable), .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata),
      .prdata (prdata), .pready (pready), .pslverr (pslverr),
      .debug_powerup_request (debug_powerup_request), .dbg_sw_mode (dbg_sw_mode),
      .dbg_tdo (dbg_tdo), .dbg_swdio_out (dbg_swdio_out), .dbg_swdio_oe (dbg_swdio_oe),
      .dbg_trst (dbg_trst), .dbg_tdi (dbg_tdi), .dbg_tms (dbg_tms), .reg_en (reg_en),
      .pin_in (pin_in), .pin_drv_lo (pin_drv_lo), .pin_drv_hi (pin_drv_hi),
      .pin_pull_up (pin_pull_up), .pin_pull_dn (pin_pull_dn), .boot_select_n (boot_select_n)
   );
   gfm_pins u_pins (
      .clk (clk), .pin_drv_lo (pin_drv_lo), .pin_drv_hi (pin_drv_hi),
      .pin_pull_up (pin_pull_up), .pin_pull_dn (pin_pull_dn), .ext_en (ext_en),
      .ext_val (ext_val), .pin_in (pin_in)
   );
   always #5 clk = ~clk;
   always @(posedge clk) dbg_tdo <= ~dbg_tdo;
   // ----
   // tasks
   // ----
   task automatic complete_run;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         err_count++;
         complete_run();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdv & m, e);
   endtask
   task automatic do_reset(input logic src, input logic lvl);
      @(posedge clk);
      rst_n <= 1'b0;
      boot_reset_src <= src;
      ext_en[PIN_BOOT] <= ~lvl;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (520) @(posedge clk);
      ext_en[PIN_BOOT] <= 1'b0;
      @(negedge clk);
      chk({31'h0, boot_select_n}, {31'h0, ~src | lvl});
      rdm(OFS_DBGST, 32'h8, {28'h0, ~src | lvl, 3'h0});
   endtask
   // ----
   // sequence
   // ----
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      complete_run();
   end
   initial begin
      do_reset(1'b1, 1'b0);
      do_reset(1'b0, 1'b0);
      do_reset(1'b1, 1'b1);
      rdm(OFS_DBGCFG, 32'h30, 32'h10);
      for (int p = 0; p < NPORT; p++) begin
         rdm(12'(p) * PORT_STEP + OFS_CFGL, 32'hFFFF_FFFF, 32'h4444);
         rdm(12'(p) * PORT_STEP + OFS_CFGH, 32'hFFFF_FFFF, 32'h4444);
      end
      for (int i = 0; i < 10; i++) begin
         wr(PORT_STEP + OFS_OUT, {28'h0, mt[i][11:8]});
         wr(PORT_STEP + OFS_CFGL, {28'h0, mt[i][15:12]});
         @(negedge clk);
         chk({28'h0, pin_drv_lo[8], pin_drv_hi[8], pin_pull_up[8], pin_pull_dn[8]},
             {28'h0, mt[i][7:4]});
         if (mt[i][1]) rdm(PORT_STEP + OFS_IN, 32'h1, {31'h0, mt[i][0]});
      end
      wr(PORT_STEP + OFS_OUT, 32'h00A5);
      rdm(PORT_STEP + OFS_OUT, 32'hFF, 32'hA5);
      wr(PORT_STEP + OFS_SET, 32'h0F);
      wr(PORT_STEP + OFS_CLR, 32'h81);
      rdm(PORT_STEP + OFS_OUT, 32'hFF, 32'h2E);
      apb(1'b0, 12'h0FC, 32'h0);
      chk({errv, rdv[30:0]}, 32'h8000_0000);
      reg_en <= 1'b0;
      @(negedge clk);
      chk({31'h0, pin_drv_lo[PIN_REGEN]}, 32'h1);
      wr(OFS_DBGCFG, 32'h0);
      @(negedge clk);
      chk({31'h0, pin_drv_lo[PIN_REGEN]}, 32'h0);
      @(posedge clk);
      dbg_sw_mode <= 1'b1;
      dbg_swdio_oe <= 1'b1;
      dbg_swdio_out <= 1'b1;
      rdm(OFS_DBGST, 32'h4, 32'h4);
      dbg_swdio_out <= 1'b0;
      wr(OFS_DBGST, 32'h0);
      rdm(OFS_DBGST, 32'h4, 32'h4);
      dbg_sw_mode <= 1'b0;
      debug_powerup_request <= 1'b1;
      wr(OFS_DBGCFG, 32'h20);
      rdm(OFS_DBGCFG, 32'h20, 32'h0);
      debug_powerup_request <= 1'b0;
      wr(OFS_DBGCFG, 32'h20);
      rdm(OFS_DBGCFG, 32'h20, 32'h20);
      wr(12'd2 * PORT_STEP + OFS_OUT, 32'h10);
      wr(12'd2 * PORT_STEP + OFS_CFGH, 32'h4441);
      @(negedge clk);
      chk({31'h0, pin_drv_hi[PIN_TMS]}, 32'h1);
      @(posedge clk);
      reset_held <= 1'b1;
      debug_powerup_request <= 1'b1;
      repeat (2) @(posedge clk);
      reset_held <= 1'b0;
      rdm(OFS_DBGCFG, 32'h20, 32'h0);
      rdm(OFS_DBGST, 32'h2, 32'h2);
      @(negedge clk);
      chk({31'h0, pin_pull_up[PIN_TMS]}, 32'h1);
      complete_run();
   end
endmodule // gfm_top_bench
